// file: rts_defs.svh
// Constants of the reset time-out sequencer
`ifndef RTS_DEFS_SVH
`define RTS_DEFS_SVH

// Clock rate of mclk
`define RTS_CLK_MHZ 50
`define RTS_CLK_KHZ 50000

// Power-up delay, printed in ms, and its cycle count
`define RTS_PUD_MS 72
`define RTS_PUD_CYC (`RTS_PUD_MS * `RTS_CLK_KHZ)

// Least brown-out duration, printed in us, and its cycle count
`define RTS_BRN_US 100
`define RTS_BRN_CYC (`RTS_BRN_US * `RTS_CLK_MHZ)

// Oscillator start-up count in oscillator cycles
`define RTS_OSC_CNT 1024

// Counter widths
`define RTS_PW_W 22
`define RTS_BRN_W 13
`define RTS_OSC_W 10

// Oscillator mode codes
`define RTS_MODE_LOWPWR 2'h0
`define RTS_MODE_XTAL 2'h1
`define RTS_MODE_FAST 2'h2
`define RTS_MODE_RC 2'h3

// Synchroniser lanes
`define RTS_NSYNC 4
`define RTS_I_POR 0
`define RTS_I_LOW 1
`define RTS_I_CLR 2
`define RTS_I_OSC 3

`endif

// file: rts_far_side.sv
// Oscillator model for the oscillator input pin
`timescale 1ns/10ps

module rts_far_side (
	input wire logic mclk,
	input wire logic slow,
	output logic osc
);
	logic [3:0] cnt_q;
	initial begin
		cnt_q = 4'h0;
		osc = 1'b0;
	end
	// Free-running crystal, half period 4 or 8 clocks
	always @(posedge mclk) begin
		cnt_q <= cnt_q + 4'h1;
		if (cnt_q == (slow ? 4'h7 : 4'h3)) begin
			cnt_q <= 4'h0;
			osc <= ~osc;
		end
	end
endmodule : rts_far_side

// file: rts_pkg.sv
// Types of the reset time-out sequencer
`include "rts_defs.svh"

package rts_pkg;

	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_DELAY = 2'b01,
		ST_OSC = 2'b10,
		ST_RUN = 2'b11
	} rts_state_e;

	typedef struct packed {
		rts_state_e st;
		logic [`RTS_NSYNC-1:0] s1;
		logic [`RTS_NSYNC-1:0] s2;
		logic [`RTS_NSYNC-1:0] s3;
		logic [`RTS_NSYNC-1:0] lvl;
		logic [`RTS_PW_W-1:0] pw_cnt;
		logic [`RTS_BRN_W-1:0] brn_cnt;
		logic brn_act;
		logic brn_hold;
		logic need_osc;
		logic wake;
		logic [`RTS_OSC_W-1:0] osc_cnt;
		logic core_reset_n;
		logic osc_stall;
		logic brownout_active;
	} rts_regs_s;

endpackage : rts_pkg

// file: rts_sequencer.sv
// Reset time-out sequencer with power-up delay and oscillator start-up
//
// What this block does
// R1: After the power-up delay, count 1024 oscillator cycles before start-up ends.
// R2: Oscillator count only in the three crystal or resonator modes.
// R3: Oscillator count only after power-on reset or wake-up from sleep.
// R4: Brown-out works only when its enable fuse is set.
// R5: Low supply lasting beyond the least brown-out time enters reset.
// R6: Stay in brown-out reset while low, then run the power-up delay.
// R7: Low supply during the power-up delay abandons it and restarts.
// R8: Brown-out enabled forces the power-up delay on.
// R9: Power-on starts delay, then oscillator count, then leaves reset.
// R10: Master clear held past all time-outs releases at once on going high.
// R11: Power-up delay is a fixed 72 ms interval holding reset.
// R12: A fuse enables the power-up delay unless brown-out overrides.
// R13: A watchdog reset acts inside without driving the master clear pin.
// R14: Core reset holds while any reset source or time-out other than the wake-up oscillator count is active.
`timescale 1ns/10ps
`include "rts_defs.svh"

module rts_sequencer
	import rts_pkg::*;
#(
	parameter logic [`RTS_PW_W-1:0] DELAY_CYCLES =
		`RTS_PW_W'(`RTS_PUD_CYC),
	parameter logic [`RTS_BRN_W-1:0] BRN_CYCLES =
		`RTS_BRN_W'(`RTS_BRN_CYC)
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic por_detect,
	input wire logic supply_low,
	input wire logic master_clear_pin_n,
	input wire logic oscillator_input_pin,
	input wire logic powerup_delay_fuse,
	input wire logic brownout_enable_fuse,
	input wire logic [1:0] osc_mode_fuse,
	input wire logic wake_from_sleep,
	input wire logic watchdog_timeout,
	output logic core_reset_n,
	output logic osc_stall,
	output logic brownout_active
);

	// ------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------

	function automatic logic is_xtal(input logic [1:0] mode);
		is_xtal = (mode == `RTS_MODE_LOWPWR) ||
			(mode == `RTS_MODE_XTAL) ||
			(mode == `RTS_MODE_FAST);
	endfunction : is_xtal

	localparam logic [`RTS_OSC_W-1:0] OSC_LAST =
		`RTS_OSC_W'(`RTS_OSC_CNT - 1);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------

	rts_regs_s q;
	rts_regs_s d;

	logic [`RTS_NSYNC-1:0] lvl_n;
	logic osc_edge;
	logic low_on;
	logic powerup_delay_timer_on;
	logic xtal;
	logic hold_src;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------

	always_comb begin
		d = q;

		// Three-stage synchronisers, level taken when stages 2 and 3 agree
		d.s1 = {oscillator_input_pin, master_clear_pin_n,
			supply_low, por_detect};
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < `RTS_NSYNC; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				lvl_n[i] = q.s3[i];
			end else begin
				lvl_n[i] = q.lvl[i];
			end
		end
		d.lvl = lvl_n;
		osc_edge = lvl_n[`RTS_I_OSC] & ~q.lvl[`RTS_I_OSC];

		low_on = brownout_enable_fuse & q.lvl[`RTS_I_LOW]; // R4
		powerup_delay_timer_on = powerup_delay_fuse | brownout_enable_fuse; // R8 R12
		xtal = is_xtal(osc_mode_fuse);

		// Brown-out filter
		if (!low_on) begin
			d.brn_cnt = '0;
			d.brn_act = 1'b0; // R6
		end else if (q.brn_cnt == BRN_CYCLES - 1'b1) begin
			d.brn_act = 1'b1; // R5
		end else begin
			d.brn_cnt = q.brn_cnt + 1'b1;
		end

		hold_src = q.lvl[`RTS_I_POR] | q.brn_act |
			(q.brn_hold & low_on);

		// Sequencer
		case (q.st)
			ST_HOLD: begin
				d.pw_cnt = '0;
				d.osc_cnt = '0;
				d.wake = 1'b0;
				if (hold_src) begin
					d.st = ST_HOLD; // R6
				end else begin
					d.brn_hold = 1'b0;
					if (powerup_delay_timer_on) begin
						d.st = ST_DELAY; // R9 R8
					end else if (q.need_osc && xtal) begin
						d.st = ST_OSC; // R9
					end else begin
						d.st = ST_RUN;
						d.need_osc = 1'b0;
					end
				end
			end
			ST_DELAY: begin
				if (low_on) begin
					d.st = ST_HOLD; // R7
					d.brn_hold = 1'b1;
					d.pw_cnt = '0;
				end else if (q.pw_cnt == DELAY_CYCLES - 1'b1) begin
					d.pw_cnt = '0;
					d.osc_cnt = '0;
					if (q.need_osc && xtal) begin
						d.st = ST_OSC; // R1 R2 R3
					end else begin
						d.st = ST_RUN;
						d.need_osc = 1'b0;
					end
				end else begin
					d.pw_cnt = q.pw_cnt + 1'b1; // R11
				end
			end
			ST_OSC: begin
				if (osc_edge) begin
					if (q.osc_cnt == OSC_LAST) begin
						d.st = ST_RUN; // R1 R9
						d.need_osc = 1'b0;
						d.wake = 1'b0;
					end else begin
						d.osc_cnt = q.osc_cnt + 1'b1;
					end
				end
			end
			ST_RUN: begin
				if (wake_from_sleep && xtal) begin
					d.st = ST_OSC; // R3
					d.wake = 1'b1;
					d.osc_cnt = '0;
				end
			end
			default: begin
				d.st = ST_HOLD;
			end
		endcase

		// Power-on and brown-out override any state
		if (q.lvl[`RTS_I_POR]) begin
			d.st = ST_HOLD;
			d.need_osc = 1'b1; // R3
			d.wake = 1'b0;
		end
		if (q.brn_act) begin
			d.st = ST_HOLD; // R5
			d.brn_hold = 1'b1;
			d.wake = 1'b0;
		end

		// Outputs; watchdog resets the core only, pin untouched
		d.core_reset_n = ((d.st == ST_RUN) ||
			((d.st == ST_OSC) && d.wake)) &&
			q.lvl[`RTS_I_CLR] && !watchdog_timeout; // R10 R13 R14
		d.osc_stall = (d.st == ST_OSC) && d.wake;
		d.brownout_active = d.brn_act | d.brn_hold;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			q.st <= ST_HOLD;
			q.s1 <= '0;
			q.s2 <= '0;
			q.s3 <= '0;
			q.lvl <= '0;
			q.pw_cnt <= '0;
			q.brn_cnt <= '0;
			q.brn_act <= 1'b0;
			q.brn_hold <= 1'b0;
			q.need_osc <= 1'b1;
			q.wake <= 1'b0;
			q.osc_cnt <= '0;
			q.core_reset_n <= 1'b0;
			q.osc_stall <= 1'b0;
			q.brownout_active <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign core_reset_n = q.core_reset_n;
	assign osc_stall = q.osc_stall;
	assign brownout_active = q.brownout_active;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	a_osc_full_count: assert property (@(posedge mclk) disable iff (!nrst)
		($past(q.st) == ST_OSC && q.st == ST_RUN) |->
		($past(q.osc_cnt) == OSC_LAST))
		else $error("oscillator count ended early"); // R1

	a_osc_xtal_only: assert property (@(posedge mclk) disable iff (!nrst)
		($past(q.st) != ST_OSC && q.st == ST_OSC) |->
		is_xtal($past(osc_mode_fuse)))
		else $error("oscillator count in non-crystal mode"); // R2

	a_osc_cause: assert property (@(posedge mclk) disable iff (!nrst)
		($past(q.st) != ST_OSC && q.st == ST_OSC) |->
		($past(q.need_osc) || q.wake))
		else $error("oscillator count without valid cause"); // R3

	a_stall_wake: assert property (@(posedge mclk) disable iff (!nrst)
		q.osc_stall |-> (q.st == ST_OSC && q.wake))
		else $error("clock stall outside a wake-up count"); // R3

	a_brn_fuse_off: assert property (@(posedge mclk) disable iff (!nrst)
		!brownout_enable_fuse |=> !q.brn_act)
		else $error("brown-out active with fuse off"); // R4

	a_brn_entry: assert property (@(posedge mclk) disable iff (!nrst)
		(q.brn_cnt == BRN_CYCLES - 1'b1 && low_on) |=>
		q.brn_act ##1 (q.st == ST_HOLD && !q.core_reset_n))
		else $error("brown-out did not enter reset"); // R5

	a_brn_flag: assert property (@(posedge mclk) disable iff (!nrst)
		q.brn_act |-> q.brownout_active)
		else $error("brown-out flag low during brown-out"); // R5

	a_brn_stay: assert property (@(posedge mclk) disable iff (!nrst)
		(q.st == ST_HOLD && q.brn_hold && low_on) |=> (q.st == ST_HOLD))
		else $error("left brown-out hold with supply low"); // R6

	a_delay_restart: assert property (@(posedge mclk) disable iff (!nrst)
		(q.st == ST_DELAY && low_on && !q.lvl[`RTS_I_POR]) |=>
		(q.st == ST_HOLD && q.brn_hold && q.pw_cnt == '0))
		else $error("power-up delay not abandoned"); // R7

	a_delay_forced: assert property (@(posedge mclk) disable iff (!nrst)
		($past(q.st) == ST_HOLD && q.st != ST_HOLD &&
		$past(brownout_enable_fuse)) |-> (q.st == ST_DELAY))
		else $error("power-up delay skipped with brown-out on"); // R8

	a_delay_end: assert property (@(posedge mclk) disable iff (!nrst)
		($past(q.st) == ST_DELAY && q.st == ST_OSC) |->
		($past(q.pw_cnt) == DELAY_CYCLES - 1'b1))
		else $error("oscillator count began before delay end"); // R9

	a_delay_holds: assert property (@(posedge mclk) disable iff (!nrst)
		(q.st == ST_DELAY) |-> !q.core_reset_n)
		else $error("core left reset during power-up delay"); // R11

	a_delay_fuse_off: assert property (@(posedge mclk) disable iff (!nrst)
		($past(q.st) == ST_HOLD && q.st != ST_HOLD &&
		!$past(powerup_delay_fuse) && !$past(brownout_enable_fuse)) |->
		(q.st != ST_DELAY))
		else $error("power-up delay ran with both fuses off"); // R12

	a_clear_release: assert property (@(posedge mclk) disable iff (!nrst)
		(q.st == ST_RUN && d.st == ST_RUN && q.lvl[`RTS_I_CLR] &&
		!watchdog_timeout) |=> q.core_reset_n)
		else $error("master clear release delayed"); // R10

	a_wdog_reset: assert property (@(posedge mclk) disable iff (!nrst)
		watchdog_timeout |=> !q.core_reset_n)
		else $error("watchdog did not reset the core"); // R13

	a_clear_holds: assert property (@(posedge mclk) disable iff (!nrst)
		!q.lvl[`RTS_I_CLR] |=> !q.core_reset_n)
		else $error("core ran with master clear low"); // R14

	a_src_holds: assert property (@(posedge mclk) disable iff (!nrst)
		(q.lvl[`RTS_I_POR] || q.brn_act) |=> !q.core_reset_n)
		else $error("core ran during power-on or brown-out"); // R14

endmodule : rts_sequencer

// file: rts_sequencer_tb.sv
// Self-checking testbench of the reset time-out sequencer
`timescale 1ns/10ps

module rts_sequencer_tb;
	localparam int PW = 20;
	localparam int BW = 8;
	localparam int OS = 8192;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic por = 1'b0;
	logic low = 1'b0;
	logic clr_n = 1'b1;
	logic pf = 1'b1;
	logic bf = 1'b0;
	logic [1:0] mode = 2'h3;
	logic wake = 1'b0;
	logic wd = 1'b0;
	logic slow = 1'b0;
	logic osc;
	logic core_n;
	logic stall;
	logic bo_act;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	int n;

	always #10 mclk = ~mclk;

	rts_sequencer #(.DELAY_CYCLES(22'h14), .BRN_CYCLES(13'h8)) dut (
		.mclk(mclk),
		.nrst(nrst),
		.por_detect(por),
		.supply_low(low),
		.master_clear_pin_n(clr_n),
		.oscillator_input_pin(osc),
		.powerup_delay_fuse(pf),
		.brownout_enable_fuse(bf),
		.osc_mode_fuse(mode),
		.wake_from_sleep(wake),
		.watchdog_timeout(wd),
		.core_reset_n(core_n),
		.osc_stall(stall),
		.brownout_active(bo_act)
	);

	rts_far_side far (.mclk(mclk), .slow(slow), .osc(osc));

	// ----------
	// Helpers
	// ----------
	task automatic stop_test;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk_bit(logic g, logic e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_bit

	task automatic chk_rng(int g, int lo, int hi);
		checked++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
		end
	endtask : chk_rng

	task automatic tick(int k);
		repeat (k) @(negedge mclk);
	endtask : tick

	task automatic wait_rel;
		n = 0;
		while (core_n !== 1'b1 && n < 20000) begin
			tick(1);
			n++;
		end
	endtask : wait_rel

	// ----------
	// Scenarios
	// ----------
	task automatic pwr(logic [1:0] m, logic p, logic b, int lo, int hi);
		mode = m;
		pf = p;
		bf = b;
		por = 1'b1;
		tick(6);
		chk_bit(core_n, 1'b0);
		por = 1'b0;
		wait_rel();
		chk_rng(n, lo, hi);
		$display("power-on test done");
	endtask : pwr

	task automatic brown;
		low = 1'b1;
		tick(BW - 3);
		low = 1'b0;
		tick(8);
		chk_bit(core_n, 1'b1);
		low = 1'b1;
		tick(BW + 8);
		chk_bit(bo_act, 1'b1);
		chk_bit(core_n, 1'b0);
		tick(40);
		chk_bit(core_n, 1'b0);
		low = 1'b0;
		tick(PW / 2);
		low = 1'b1;
		tick(3);
		low = 1'b0;
		wait_rel();
		chk_rng(n, PW, PW + 12);
		bf = 1'b0;
		low = 1'b1;
		tick(BW + 8);
		chk_bit(bo_act, 1'b0);
		chk_bit(core_n, 1'b1);
		low = 1'b0;
		$display("brown-out test done");
	endtask : brown

	task automatic wdog;
		wd = 1'b1;
		tick(2);
		chk_bit(core_n, 1'b0);
		wd = 1'b0;
		tick(2);
		chk_bit(core_n, 1'b1);
		chk_bit(stall, 1'b0);
		$display("watchdog test done");
	endtask : wdog

	task automatic wake_up(logic [1:0] m, logic e);
		mode = m;
		slow = 1'b1;
		tick(2);
		wake = 1'b1;
		tick(1);
		wake = 1'b0;
		tick(2);
		chk_bit(stall, e);
		chk_bit(core_n, 1'b1);
		tick(16300);
		chk_bit(stall, e);
		tick(160);
		chk_bit(stall, 1'b0);
		$display("wake test done");
	endtask : wake_up

	task automatic clear_test;
		mode = 2'h3;
		clr_n = 1'b0;
		por = 1'b1;
		tick(6);
		por = 1'b0;
		tick(PW + 40);
		chk_bit(core_n, 1'b0);
		clr_n = 1'b1;
		wait_rel();
		chk_rng(n, 1, 6);
		$display("master clear test done");
	endtask : clear_test

	initial begin
		tick(5);
		nrst = 1'b1;
		pwr(2'h3, 1'b1, 1'b0, PW, PW + 12);
		pwr(2'h3, 1'b0, 1'b0, 1, 12);
		pwr(2'h3, 1'b0, 1'b1, PW, PW + 12);
		for (int m = 0; m < 3; m++) begin
			pwr(2'(m), 1'b1, 1'b1, PW + OS - 12, PW + OS + 16);
		end
		brown();
		wdog();
		wake_up(2'h2, 1'b1);
		wake_up(2'h3, 1'b0);
		clear_test();
		stop_test();
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			stop_test();
		end
	end
endmodule : rts_sequencer_tb
